/* File: inc/trim_regs_pkg.sv */
// Purpose: Constants and types for the trim and swap-overlap register bank.
// Assumes: Registers sit on AHB-Lite, one aligned word each, byte address = 4 x index.
// Notes:   Indices keep the printed offsets; the low bits of each word hold the field.
package trim_regs_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices (byte address is four times the index)
    localparam logic [7:0] GAIN_IDX = 8'h7a;
    localparam logic [7:0] REF_IDX = 8'h7c;
    localparam logic [7:0] TERM_A_IDX = 8'h7e;
    localparam logic [7:0] TERM_B_IDX = 8'h7f;
    localparam logic [7:0] TERM_C_IDX = 8'h80;
    localparam logic [7:0] TERM_D_IDX = 8'h81;
    localparam logic [7:0] DLY_IDX = 8'h9a;

    ////////////////////////////////////////////////////////////////////////////
    // Field widths, all fields start at bit 0
    localparam int GAIN_W = 8;
    localparam int REF_W = 4;
    localparam int TERM_W = 8;
    localparam int DLY_W = 5;
    localparam int OVL_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [3:0] REF_RST = 4'h0;
    localparam logic [7:0] TERM_RST = 8'h00;
    localparam logic [4:0] DLY_RST = 5'h08;

    ////////////////////////////////////////////////////////////////////////////
    // Overlap length = OVL_BASE + OVL_SCALE x delay, in clock cycles
    localparam logic [6:0] OVL_BASE = 7'h04;
    localparam int OVL_SCALE_SHIFT = 1;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // State types
    typedef enum logic [1:0]
    {
        LD_FUSE = 2'b00,
        LD_RUN = 2'b01
    } load_state_t;

    typedef enum logic [1:0]
    {
        OV_IDLE = 2'b00,
        OV_SHARE = 2'b01
    } overlap_state_t;

endpackage

/* File: verilog/swap_overlap_timer.sv */
// Purpose: Times the window in which two swapping cores sample the same input.
// Assumes: swap_start_i is a one-cycle pulse from the calibration engine.
// Notes:   A start while a window runs is ignored; delay is latched at start.
module swap_overlap_timer
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Control
    input wire logic swap_start_i,
    input wire logic [4:0] delay_i,
    // Status
    output logic overlap_o
);

    trim_regs_pkg::overlap_state_t st_q;
    trim_regs_pkg::overlap_state_t st_d;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic [6:0] len_w;
    logic [6:0] dly_lat_q;
    logic [6:0] seen_q;

    ////////////////////////////////////////////////////////////////////////////
    // overlap length
    assign len_w = trim_regs_pkg::OVL_BASE
                   + 7'({2'b00, delay_i} << trim_regs_pkg::OVL_SCALE_SHIFT);

    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        unique case (st_q)
            trim_regs_pkg::OV_IDLE:
            begin
                if (swap_start_i)
                begin
                    st_d = trim_regs_pkg::OV_SHARE;
                    cnt_d = len_w - 7'h01;
                end
            end
            trim_regs_pkg::OV_SHARE:
            begin
                if (cnt_q == 7'h00)
                    st_d = trim_regs_pkg::OV_IDLE;
                else
                    cnt_d = cnt_q - 7'h01;
            end
            default:
            begin
                st_d = trim_regs_pkg::OV_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            st_q <= trim_regs_pkg::OV_IDLE;
            cnt_q <= 7'h00;
            overlap_o <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            overlap_o <= (st_d == trim_regs_pkg::OV_SHARE);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            dly_lat_q <= 7'h00;
            seen_q <= 7'h00;
        end
        else
        begin
            if (swap_start_i && st_q == trim_regs_pkg::OV_IDLE)
                dly_lat_q <= len_w;
            seen_q <= overlap_o ? seen_q + 7'h01 : 7'h00;
        end
    end

    overlap_length_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(overlap_o) |-> $past(seen_q) + 7'h01 == dly_lat_q)
        else $error("Overlap window length differs from four plus twice delay");

    overlap_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (swap_start_i && !overlap_o && st_q == trim_regs_pkg::OV_IDLE) |=> overlap_o [*4])
        else $error("Overlap window shorter than four cycles");

endmodule

/* File: verilog/trim_and_swap_delay_regs.sv */
// Purpose: Trim and swap-overlap delay register bank behind an AHB-Lite slave.
// Assumes: Fuse inputs are stable at reset release; one clock for bus and converter logic.
// Notes:   Reserved bits are not stored and read as zero; unmapped reads return zero.
//
// The AHB-Lite register port is this design's own decision.
module trim_and_swap_delay_regs
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Factory fuse values
    input wire logic [7:0] fuse_gain_i,
    input wire logic [3:0] fuse_reference_i,
    input wire logic [7:0] fuse_term_a_i,
    input wire logic [7:0] fuse_term_b_i,
    input wire logic [7:0] fuse_term_c_i,
    input wire logic [7:0] fuse_term_d_i,
    // Calibration engine
    input wire logic cal_en_i,
    input wire logic swap_start_i,
    // Trim outputs to the analog cores
    output logic [7:0] core_gain_adjust_o,
    output logic [3:0] reference_adjust_o,
    output logic [7:0] input_termination_adjust_a_o,
    output logic [7:0] input_termination_adjust_b_o,
    output logic [7:0] input_termination_adjust_c_o,
    output logic [7:0] input_termination_adjust_d_o,
    output logic [4:0] swap_overlap_delay_o,
    output logic swap_overlap_o
);

    trim_regs_pkg::load_state_t ld_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [7:0] gain_q;
    logic [7:0] gain_d;
    logic [3:0] ref_q;
    logic [3:0] ref_d;
    logic [7:0] term_a_q;
    logic [7:0] term_a_d;
    logic [7:0] term_b_q;
    logic [7:0] term_b_d;
    logic [7:0] term_c_q;
    logic [7:0] term_c_d;
    logic [7:0] term_d_q;
    logic [7:0] term_d_d;
    logic [4:0] dly_q;
    logic [4:0] dly_d;
    logic [31:0] rd_word;
    logic ap_fire;
    logic addr_ok;
    logic [7:0] addr_idx;
    logic loading;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    function automatic logic wr_hit(input logic pend, input logic [7:0] idx, input logic [7:0] want);
        wr_hit = pend && (idx == want);
    endfunction

    function automatic logic [31:0] word8(input logic [7:0] v);
        word8 = {24'h0000_00, v};
    endfunction

    assign loading = (ld_q == trim_regs_pkg::LD_FUSE);
    assign ap_fire = hsel_i && hready_i && (htrans_i == trim_regs_pkg::HTRANS_NONSEQ) && !loading;
    assign addr_idx = haddr_i[9:2];
    assign addr_ok = (haddr_i[31:10] == 22'h00_0000) && (haddr_i[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////////
    // Next values: fuse load first, then a pending data-phase write

    assign gain_d = loading ? fuse_gain_i
                  : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::GAIN_IDX) ? hwdata_i[7:0] : gain_q;
    assign ref_d = loading ? fuse_reference_i
                 : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::REF_IDX) ? hwdata_i[3:0] : ref_q;
    assign term_a_d = loading ? fuse_term_a_i
                    : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::TERM_A_IDX) ? hwdata_i[7:0] : term_a_q;
    assign term_b_d = loading ? fuse_term_b_i
                    : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::TERM_B_IDX) ? hwdata_i[7:0] : term_b_q;
    assign term_c_d = loading ? fuse_term_c_i
                    : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::TERM_C_IDX) ? hwdata_i[7:0] : term_c_q;
    assign term_d_d = loading ? fuse_term_d_i
                    : wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::TERM_D_IDX) ? hwdata_i[7:0] : term_d_q;
    // five-bit delay field, not fuse loaded
    assign dly_d = wr_hit(wr_pend_q, wr_idx_q, trim_regs_pkg::DLY_IDX) ? hwdata_i[4:0] : dly_q;

    ////////////////////////////////////////////////////////////////////////////
    // Read mux over next values so a read right after a write sees it

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (addr_ok)
        begin
            unique case (addr_idx)
                trim_regs_pkg::GAIN_IDX: rd_word = word8(gain_d);
                trim_regs_pkg::REF_IDX: rd_word = word8({4'h0, ref_d});
                trim_regs_pkg::TERM_A_IDX: rd_word = word8(term_a_d);
                trim_regs_pkg::TERM_B_IDX: rd_word = word8(term_b_d);
                trim_regs_pkg::TERM_C_IDX: rd_word = word8(term_c_d);
                trim_regs_pkg::TERM_D_IDX: rd_word = word8(term_d_d);
                trim_regs_pkg::DLY_IDX: rd_word = word8({3'h0, dly_d});
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load sequencer and bus slave

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            ld_q <= trim_regs_pkg::LD_FUSE;
            hreadyout_o <= 1'b0;
            hresp_o <= trim_regs_pkg::HRESP_OKAY;
            hrdata_o <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end
        else
        begin
            ld_q <= trim_regs_pkg::LD_RUN;
            hreadyout_o <= 1'b1;
            hresp_o <= trim_regs_pkg::HRESP_OKAY;
            wr_pend_q <= ap_fire && hwrite_i && addr_ok;
            wr_idx_q <= addr_idx;
            hrdata_o <= (ap_fire && !hwrite_i) ? rd_word : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trim registers

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            gain_q <= trim_regs_pkg::GAIN_RST;
            ref_q <= trim_regs_pkg::REF_RST;
            term_a_q <= trim_regs_pkg::TERM_RST;
            term_b_q <= trim_regs_pkg::TERM_RST;
            term_c_q <= trim_regs_pkg::TERM_RST;
            term_d_q <= trim_regs_pkg::TERM_RST;
            dly_q <= trim_regs_pkg::DLY_RST;
        end
        else
        begin
            gain_q <= gain_d;
            ref_q <= ref_d;
            term_a_q <= term_a_d;
            term_b_q <= term_b_d;
            term_c_q <= term_c_d;
            term_d_q <= term_d_d;
            dly_q <= dly_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs to the analog side

    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            core_gain_adjust_o <= trim_regs_pkg::GAIN_RST;
            reference_adjust_o <= trim_regs_pkg::REF_RST;
            input_termination_adjust_a_o <= trim_regs_pkg::TERM_RST;
            input_termination_adjust_b_o <= trim_regs_pkg::TERM_RST;
            input_termination_adjust_c_o <= trim_regs_pkg::TERM_RST;
            input_termination_adjust_d_o <= trim_regs_pkg::TERM_RST;
            swap_overlap_delay_o <= trim_regs_pkg::DLY_RST;
        end
        else
        begin
            // one gain trim for all cores
            core_gain_adjust_o <= gain_q;
            reference_adjust_o <= ref_q;
            input_termination_adjust_a_o <= term_a_q;
            input_termination_adjust_b_o <= term_b_q;
            input_termination_adjust_c_o <= term_c_q;
            input_termination_adjust_d_o <= term_d_q;
            // delay applied only while calibration is off
            if (!cal_en_i)
                swap_overlap_delay_o <= dly_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Swap overlap window

    swap_overlap_timer u_timer
    (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .swap_start_i(swap_start_i),
        .delay_i(swap_overlap_delay_o),
        .overlap_o(swap_overlap_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence addr_wr(logic [7:0] idx);
        ap_fire && hwrite_i && addr_ok && addr_idx == idx;
    endsequence

    sequence addr_rd(logic [7:0] idx);
        ap_fire && !hwrite_i && addr_ok && addr_idx == idx && !wr_pend_q;
    endsequence

    gain_fuse_load_a: assert property (loading |=> gain_q == $past(fuse_gain_i, 1))
        else $error("Gain trim did not take its fuse value");

    bus_held_a: assert property (loading |-> !hreadyout_o ##1 hreadyout_o)
        else $error("Bus ready during fuse load");

    gain_write_a: assert property (addr_wr(trim_regs_pkg::GAIN_IDX) ##1 1'b1
        |=> gain_q == $past(hwdata_i[7:0]) ##1 core_gain_adjust_o == $past(gain_q))
        else $error("Gain trim write lost");

    ref_nibble_a: assert property (addr_wr(trim_regs_pkg::REF_IDX) ##1 1'b1
        |=> ##1 reference_adjust_o == $past(hwdata_i[3:0], 2))
        else $error("Reference trim did not take low nibble");

    term_c_write_a: assert property (addr_wr(trim_regs_pkg::TERM_C_IDX) ##1 1'b1
        |=> term_c_q == $past(hwdata_i[7:0]) && term_d_q == $past(term_d_q))
        else $error("Termination trim C write wrong");

    dly_field_a: assert property (addr_wr(trim_regs_pkg::DLY_IDX) ##1 1'b1
        |=> dly_q == $past(hwdata_i[4:0]))
        else $error("Delay field write wrong");

    dly_readback_a: assert property (addr_rd(trim_regs_pkg::DLY_IDX)
        |=> hrdata_o == {27'h000_0000, $past(dly_q)})
        else $error("Delay readback wrong or upper bits set");

    dly_reset_a: assert property (loading |-> dly_q == trim_regs_pkg::DLY_RST)
        else $error("Delay not at reset value after reset");

    dly_frozen_a: assert property (cal_en_i |=> $stable(swap_overlap_delay_o))
        else $error("Applied delay changed while calibration enabled");

endmodule

/* File: tb/trim_and_swap_delay_regs_tb.sv */
// Purpose: Self-checking bench for the trim and swap-overlap register bank.
// Assumes: Master drives right after rising edges; hready is the slave's own hreadyout.
// Notes:   Fuse inputs carry distinct patterns so that the load after reset is visible.
module trim_and_swap_delay_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////////
    // Signals
    logic core_clk_i;
    logic rst_i;
    logic hsel_i;
    logic [31:0] haddr_i;
    logic [1:0] htrans_i;
    logic hwrite_i;
    logic [2:0] hsize_i;
    logic [31:0] hwdata_i;
    logic hready_i;
    logic [31:0] hrdata_o;
    logic hreadyout_o;
    logic hresp_o;
    logic [7:0] fuse_gain_i;
    logic [3:0] fuse_reference_i;
    logic [7:0] fuse_term_a_i;
    logic [7:0] fuse_term_b_i;
    logic [7:0] fuse_term_c_i;
    logic [7:0] fuse_term_d_i;
    logic cal_en_i;
    logic swap_start_i;
    logic [7:0] core_gain_adjust_o;
    logic [3:0] reference_adjust_o;
    logic [7:0] input_termination_adjust_a_o;
    logic [7:0] input_termination_adjust_b_o;
    logic [7:0] input_termination_adjust_c_o;
    logic [7:0] input_termination_adjust_d_o;
    logic [4:0] swap_overlap_delay_o;
    logic swap_overlap_o;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] idx_tab [7];

    assign hready_i = hreadyout_o;

    trim_and_swap_delay_regs u_trim_and_swap_delay_regs
    (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .fuse_gain_i(fuse_gain_i), .fuse_reference_i(fuse_reference_i), .fuse_term_a_i(fuse_term_a_i),
        .fuse_term_b_i(fuse_term_b_i), .fuse_term_c_i(fuse_term_c_i), .fuse_term_d_i(fuse_term_d_i),
        .cal_en_i(cal_en_i), .swap_start_i(swap_start_i), .core_gain_adjust_o(core_gain_adjust_o),
        .reference_adjust_o(reference_adjust_o), .input_termination_adjust_a_o(input_termination_adjust_a_o),
        .input_termination_adjust_b_o(input_termination_adjust_b_o),
        .input_termination_adjust_c_o(input_termination_adjust_c_o),
        .input_termination_adjust_d_o(input_termination_adjust_d_o),
        .swap_overlap_delay_o(swap_overlap_delay_o), .swap_overlap_o(swap_overlap_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Mismatches %0d, comparisons %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Current trim port value behind a register index
    function automatic logic [31:0] port_of(input logic [7:0] idx);
        case (idx)
            trim_regs_pkg::GAIN_IDX: port_of = {24'h0000_00, core_gain_adjust_o};
            trim_regs_pkg::REF_IDX: port_of = {28'h000_0000, reference_adjust_o};
            trim_regs_pkg::TERM_A_IDX: port_of = {24'h0000_00, input_termination_adjust_a_o};
            trim_regs_pkg::TERM_B_IDX: port_of = {24'h0000_00, input_termination_adjust_b_o};
            trim_regs_pkg::TERM_C_IDX: port_of = {24'h0000_00, input_termination_adjust_c_o};
            trim_regs_pkg::TERM_D_IDX: port_of = {24'h0000_00, input_termination_adjust_d_o};
            default: port_of = {27'h000_0000, swap_overlap_delay_o};
        endcase
    endfunction

    function automatic logic [31:0] mask_of(input logic [7:0] idx);
        if (idx == trim_regs_pkg::REF_IDX)
            mask_of = 32'h0000_000f;
        else if (idx == trim_regs_pkg::DLY_IDX)
            mask_of = 32'h0000_001f;
        else
            mask_of = 32'h0000_00ff;
    endfunction

    // One AHB-Lite single transfer; entered and left just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        logic rdy;
        hsel_i <= 1'b1;
        haddr_i <= addr;
        hwrite_i <= wr;
        hsize_i <= 3'b010;
        htrans_i <= trim_regs_pkg::HTRANS_NONSEQ;
        n = 0;
        do
        begin
            @(negedge core_clk_i);
            rdy = hreadyout_o;
            @(posedge core_clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 50);
        htrans_i <= 2'b00;
        hsel_i <= 1'b0;
        hwdata_i <= wd;
        do
        begin
            @(negedge core_clk_i);
            rdy = hreadyout_o;
            rd = hrdata_o;
            check("hresp", {31'h0000_0000, hresp_o}, 32'h0000_0000);
            @(posedge core_clk_i);
            n++;
        end while (rdy !== 1'b1 && n < 100);
        if (n >= 100)
            check("bus_timeout", 32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic settle_look(input string name, input logic [7:0] idx, input logic [31:0] exp);
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(name, port_of(idx), exp);
        @(posedge core_clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic fuse_defaults();
        logic [31:0] rd;
        logic [31:0] exp [7];
        exp = '{32'h0000_00a5, 32'h0000_0009, 32'h0000_003c, 32'h0000_00c3, 32'h0000_005a, 32'h0000_0096,
                32'h0000_0008};
        for (int k = 0; k < 7; k++)
        begin
            bus(1'b0, {22'h00_0000, idx_tab[k], 2'b00}, 32'h0000_0000, rd);
            check("reset_read", rd, exp[k]);
            check("reset_port", port_of(idx_tab[k]), exp[k]);
        end
    endtask

    task automatic rw_all(input logic [31:0] pattern);
        logic [31:0] rd;
        logic [31:0] wd;
        for (int k = 0; k < 7; k++)
        begin
            wd = pattern + 32'(k);
            if (idx_tab[k] == trim_regs_pkg::REF_IDX || idx_tab[k] == trim_regs_pkg::DLY_IDX)
                wd = wd & mask_of(idx_tab[k]);
            bus(1'b1, {22'h00_0000, idx_tab[k], 2'b00}, wd, rd);
            bus(1'b0, {22'h00_0000, idx_tab[k], 2'b00}, 32'h0000_0000, rd);
            check("rw_read", rd, wd & mask_of(idx_tab[k]));
            settle_look("rw_port", idx_tab[k], wd & mask_of(idx_tab[k]));
        end
    endtask

    task automatic unmapped_access();
        logic [31:0] rd;
        bus(1'b1, 32'h0000_0244, 32'hffff_ffff, rd);
        bus(1'b0, 32'h0000_0244, 32'h0000_0000, rd);
        check("unmapped_read", rd, 32'h0000_0000);
        bus(1'b1, 32'h0000_01e9, 32'h0000_0011, rd);
        bus(1'b0, 32'h0000_01e9, 32'h0000_0000, rd);
        check("misaligned_read", rd, 32'h0000_0000);
        bus(1'b0, 32'h0000_01e8, 32'h0000_0000, rd);
        check("gain_untouched", rd, 32'h0000_0060);
    endtask

    task automatic cal_freeze();
        logic [31:0] rd;
        bus(1'b1, 32'h0000_0268, 32'h0000_0003, rd);
        settle_look("delay_free", trim_regs_pkg::DLY_IDX, 32'h0000_0003);
        cal_en_i <= 1'b1;
        bus(1'b1, 32'h0000_0268, 32'h0000_0009, rd);
        settle_look("delay_frozen", trim_regs_pkg::DLY_IDX, 32'h0000_0003);
        bus(1'b0, 32'h0000_0268, 32'h0000_0000, rd);
        check("delay_stored", rd, 32'h0000_0009);
        cal_en_i <= 1'b0;
        settle_look("delay_release", trim_regs_pkg::DLY_IDX, 32'h0000_0009);
    endtask

    task automatic overlap_len(input logic [4:0] d, input logic retrig);
        logic [31:0] rd;
        int n;
        bus(1'b1, 32'h0000_0268, {27'h000_0000, d}, rd);
        settle_look("delay_applied", trim_regs_pkg::DLY_IDX, {27'h000_0000, d});
        swap_start_i <= 1'b1;
        @(posedge core_clk_i);
        swap_start_i <= 1'b0;
        n = 0;
        for (int i = 0; i < 100; i++)
        begin
            @(negedge core_clk_i);
            if (swap_overlap_o === 1'b1)
                n++;
            @(posedge core_clk_i);
            swap_start_i <= (retrig && i == 5);
        end
        check("overlap_cycles", 32'(n), 32'h0000_0004 + 32'h0000_0002 * 32'(d));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    initial
    begin
        #(40 * 20000);
        n_errors++;
        close_out();
    end

    initial
    begin
        idx_tab = '{trim_regs_pkg::GAIN_IDX, trim_regs_pkg::REF_IDX, trim_regs_pkg::TERM_A_IDX,
                    trim_regs_pkg::TERM_B_IDX, trim_regs_pkg::TERM_C_IDX, trim_regs_pkg::TERM_D_IDX,
                    trim_regs_pkg::DLY_IDX};
        rst_i = 1'b1;
        hsel_i = 1'b0;
        haddr_i = 32'h0000_0000;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        hsize_i = 3'b010;
        hwdata_i = 32'h0000_0000;
        fuse_gain_i = 8'ha5;
        fuse_reference_i = 4'h9;
        fuse_term_a_i = 8'h3c;
        fuse_term_b_i = 8'hc3;
        fuse_term_c_i = 8'h5a;
        fuse_term_d_i = 8'h96;
        cal_en_i = 1'b0;
        swap_start_i = 1'b0;
        repeat (19) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check("ready_in_reset", {31'h0000_0000, hreadyout_o}, 32'h0000_0000);
        @(posedge core_clk_i);
        rst_i <= 1'b0;
        fuse_defaults();
        rw_all(32'hffff_fff0);
        rw_all(32'h0000_0060);
        unmapped_access();
        cal_freeze();
        overlap_len(5'h00, 1'b0);
        overlap_len(5'h07, 1'b0);
        overlap_len(5'h08, 1'b1);
        overlap_len(5'h1f, 1'b0);
        close_out();
    end
endmodule
